// ===== include/csps_cfg.svh
// Offsets, field positions, reset values and widths of the socket present state block.
`ifndef CSPS_CFG_SVH
`define CSPS_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CSPS_ADDR_W        8
`define CSPS_OFS_STATE     8'h08
`define CSPS_RESET_HIGH    32'h3000_0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSPS_B_YY_SOCK     31
`define CSPS_B_XX_SOCK     30
`define CSPS_B_THREE_SOCK  29
`define CSPS_B_FIVE_SOCK   28
`define CSPS_B_YY_CARD     13
`define CSPS_B_XX_CARD     12
`define CSPS_B_THREE_CARD  11
`define CSPS_B_FIVE_CARD   10
`define CSPS_B_BAD_VCC     9
`define CSPS_B_LOSS        8
`define CSPS_B_UNRECOG     7
`define CSPS_B_READY       6
`define CSPS_B_CARDBUS     5
`define CSPS_B_SIXTEEN     4
`define CSPS_B_POWERED     3
`define CSPS_B_DETECT2     2
`define CSPS_B_DETECT1     1
`define CSPS_B_STATUS      0

// ----------------------------------------------------------------------
// Synchroniser
// ----------------------------------------------------------------------
`define CSPS_SYNC_W        6

`endif

// ===== include/csps_pkg.sv
// Types shared by the socket present state block.
package csps_pkg;

    // Result of one card interrogation.
    typedef struct packed {
        logic [3:0] volt_support;  // Y.Y, X.X, 3.3 V, 5 V support, high to low.
        logic       unrecognized;  // Card could not be identified.
        logic       cardbus;       // CardBus card found.
        logic       sixteen_bit;   // 16-bit card found.
    } csps_interrog_t;

    // Card and reset pins, as seen after synchronisation.
    typedef struct packed {
        logic global_reset_pin;    // Global reset level.
        logic pci_reset_pin;       // PCI reset level.
        logic ready_irq;           // Ready or interrupt request pin.
        logic detect_two;          // Second card-detect pin.
        logic detect_one;          // First card-detect pin.
        logic status_change;       // Status-change pin.
    } csps_pins_t;

endpackage : csps_pkg

// ===== hdl/csps_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/10ps
module csps_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    // Levels in and out
    input  wire logic [WIDTH-1:0] i_async,
    input  wire logic [WIDTH-1:0] i_rst_val,
    output logic      [WIDTH-1:0] o_sync
);
    // First stage; read only by the second stage.
    logic [WIDTH-1:0] meta;

    // Both stages load a constant-like reset pattern given by the parent.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            meta   <= i_rst_val;
            o_sync <= i_rst_val;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule : csps_sync

// ===== hdl/csps_state_reg.sv
// Socket present state register with card interrogation capture and pin tracking.
`include "csps_cfg.svh"
`timescale 1ns/10ps
module csps_state_reg (
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_sys_rst,
    // Register read port
    input  wire logic                       i_rd_en,
    input  wire logic [`CSPS_ADDR_W-1:0]    i_rd_addr,
    output logic      [31:0]                o_rd_data,
    output logic                            o_rd_valid,
    // Force event register write
    input  wire logic                       i_force_we,
    input  wire logic [31:0]                i_force_data,
    // Device control and power management
    input  wire logic                       i_five_volt_disable,
    input  wire logic                       i_pme_enable,
    // Interrogation logic
    input  wire logic                       i_interrog_busy,
    input  wire logic                       i_interrog_done,
    input  wire csps_pkg::csps_interrog_t   i_interrog_result,
    // Power control status
    input  wire logic                       i_socket_powered,
    input  wire logic                       i_bad_supply_req,
    input  wire logic                       i_removal_loss,
    // Pins from the socket and the reset pins
    input  wire logic                       i_global_reset_pin,
    input  wire logic                       i_pci_reset_pin,
    input  wire logic                       i_ready_irq_pin,
    input  wire logic                       i_detect_two_pin,
    input  wire logic                       i_detect_one_pin,
    input  wire logic                       i_status_change_pin,
    // Events toward the socket event register
    output logic      [3:0]                 o_event_set
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------

    // Raw pins gathered into one group.
    csps_pkg::csps_pins_t pins_raw;
    // Pins after two flip-flops.
    csps_pkg::csps_pins_t pins;
    // Reset pattern of the synchroniser: detect lines idle high.
    csps_pkg::csps_pins_t pins_idle;

    // Gather the raw pins.
    always_comb begin
        pins_raw.global_reset_pin = i_global_reset_pin;
        pins_raw.pci_reset_pin    = i_pci_reset_pin;
        pins_raw.ready_irq        = i_ready_irq_pin;
        pins_raw.detect_two       = i_detect_two_pin;
        pins_raw.detect_one       = i_detect_one_pin;
        pins_raw.status_change    = i_status_change_pin;
        pins_idle                 = csps_pkg::csps_pins_t'(6'h06);
    end

    // Every asynchronous pin passes two stages before use.
    csps_sync #(
        .WIDTH     (`CSPS_SYNC_W)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_async   (pins_raw),
        .i_rst_val (pins_idle),
        .o_sync    (pins)
    );

    // ------------------------------------------------------------------
    // Context clear
    // ------------------------------------------------------------------

    // Clear of the power-management context bits.
    logic ctx_clr;

    // Global reset always clears; PCI reset only while PME is off.
    always_comb begin
        ctx_clr = pins.global_reset_pin
                | (pins.pci_reset_pin & ~i_pme_enable);
    end

    // ------------------------------------------------------------------
    // Socket supply overrides
    // ------------------------------------------------------------------

    // Y.Y and X.X supply claims, forced by software.
    logic sock_yy;
    logic sock_xx;
    // 3.3 V supply claim; set unless forced off.
    logic sock_three;
    // Next values.
    logic next_sock_yy;
    logic next_sock_xx;
    logic next_sock_three;

    // A force write loads the three socket supply bits.
    always_comb begin
        next_sock_yy    = sock_yy;
        next_sock_xx    = sock_xx;
        next_sock_three = sock_three;
        if (i_force_we) begin
            // Software overrides the supply claims.
            next_sock_yy    = i_force_data[`CSPS_B_YY_SOCK];
            next_sock_xx    = i_force_data[`CSPS_B_XX_SOCK];
            next_sock_three = ~i_force_data[`CSPS_B_THREE_SOCK];
        end
    end

    // Register the supply claims.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            sock_yy    <= 1'b0;
            sock_xx    <= 1'b0;
            sock_three <= 1'b1;
        end else begin
            sock_yy    <= next_sock_yy;
            sock_xx    <= next_sock_xx;
            sock_three <= next_sock_three;
        end
    end

    // ------------------------------------------------------------------
    // Card information captured at interrogation
    // ------------------------------------------------------------------

    // Voltage support of the inserted card.
    logic [3:0] card_volts;
    // Card type flags.
    logic       cardbus_type_flag;
    logic       sixteen_bit_type_flag;
    // Unrecognizable card flag.
    logic       unrecognized_card_flag;
    // Sticky supply and loss flags.
    logic       invalid_supply_request;
    logic       removal_loss_flag;
    // Next values.
    logic [3:0] next_card_volts;
    logic       next_cardbus;
    logic       next_sixteen;
    logic       next_unrecog;
    logic       next_invalid;
    logic       next_loss;

    // Interrogation result is taken once per pass; force writes set bits.
    always_comb begin
        next_card_volts = card_volts;
        next_cardbus    = cardbus_type_flag;
        next_sixteen    = sixteen_bit_type_flag;
        next_unrecog    = unrecognized_card_flag;
        next_invalid    = invalid_supply_request | i_bad_supply_req;
        next_loss       = removal_loss_flag | i_removal_loss;
        if (i_interrog_done) begin
            // Capture only when a pass completes, held otherwise.
            next_card_volts = i_interrog_result.volt_support;
            next_cardbus    = i_interrog_result.cardbus;
            next_sixteen    = i_interrog_result.sixteen_bit;
            if (i_interrog_result.unrecognized) begin
                // An unknown card sets the flag.
                next_unrecog = 1'b1;
            end else begin
                // A valid card or a context clear clears it again.
                next_unrecog = 1'b0;
            end
        end
        if (i_force_we) begin
            // Writing ones to the force bits sets the matching flags.
            next_card_volts = next_card_volts
                            | i_force_data[`CSPS_B_YY_CARD:`CSPS_B_FIVE_CARD];
            next_invalid    = next_invalid | i_force_data[`CSPS_B_BAD_VCC];
            next_loss       = next_loss | i_force_data[`CSPS_B_LOSS];
            next_unrecog    = next_unrecog | i_force_data[`CSPS_B_UNRECOG];
            next_cardbus    = next_cardbus | i_force_data[`CSPS_B_CARDBUS];
            next_sixteen    = next_sixteen | i_force_data[`CSPS_B_SIXTEEN];
        end
    end

    // Register the card information; the context clear empties it.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || ctx_clr) begin
            card_volts             <= 4'h0;
            cardbus_type_flag      <= 1'b0;
            sixteen_bit_type_flag  <= 1'b0;
            unrecognized_card_flag <= 1'b0;
            invalid_supply_request <= 1'b0;
            removal_loss_flag      <= 1'b0;
        end else begin
            card_volts             <= next_card_volts;
            cardbus_type_flag      <= next_cardbus;
            sixteen_bit_type_flag  <= next_sixteen;
            unrecognized_card_flag <= next_unrecog;
            invalid_supply_request <= next_invalid;
            removal_loss_flag      <= next_loss;
        end
    end

    // ------------------------------------------------------------------
    // Live socket levels
    // ------------------------------------------------------------------

    // Card-detect levels, frozen while a card is being identified.
    logic detect_two_level;
    logic detect_one_level;
    // Powered state of the socket.
    logic socket_powered_state;
    // Low nibble as last seen, for change detection.
    logic [3:0] low_prev;
    // Low nibble now.
    logic [3:0] low_now;
    // Next values.
    logic       next_detect_two;
    logic       next_detect_one;
    logic [3:0] next_event;

    // Follow the detect pins except during identification.
    always_comb begin
        next_detect_two = detect_two_level;
        next_detect_one = detect_one_level;
        if (!i_interrog_busy) begin
            // The bridge drives these lines itself while busy.
            next_detect_two = pins.detect_two;
            next_detect_one = pins.detect_one;
        end
        low_now    = {socket_powered_state, detect_two_level,
                      detect_one_level, pins.status_change};
        next_event = (low_now ^ low_prev) & {4{~ctx_clr}};
    end

    // Register the levels and the change pulses.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            detect_two_level     <= 1'b1;
            detect_one_level     <= 1'b1;
            socket_powered_state <= 1'b0;
            low_prev             <= 4'h6;
            o_event_set          <= 4'h0;
        end else begin
            detect_two_level     <= next_detect_two;
            detect_one_level     <= next_detect_one;
            socket_powered_state <= i_socket_powered;
            low_prev             <= low_now;
            o_event_set          <= next_event;
        end
    end

    // ------------------------------------------------------------------
    // Register image and read port
    // ------------------------------------------------------------------

    // Assembled register value.
    logic [31:0] state_word;
    // Next read answer.
    logic [31:0] next_rd_data;
    logic        next_rd_valid;

    // Build the word; reserved bits stay zero.
    always_comb begin
        state_word                     = 32'h0000_0000;
        state_word[`CSPS_B_YY_SOCK]    = sock_yy;
        state_word[`CSPS_B_XX_SOCK]    = sock_xx;
        state_word[`CSPS_B_THREE_SOCK] = sock_three;
        state_word[`CSPS_B_FIVE_SOCK]  = ~i_five_volt_disable;
        state_word[`CSPS_B_YY_CARD:`CSPS_B_FIVE_CARD] = card_volts;
        state_word[`CSPS_B_BAD_VCC]    = invalid_supply_request;
        state_word[`CSPS_B_LOSS]       = removal_loss_flag;
        state_word[`CSPS_B_UNRECOG]    = unrecognized_card_flag;
        state_word[`CSPS_B_READY]      = pins.ready_irq;
        state_word[`CSPS_B_CARDBUS]    = cardbus_type_flag;
        state_word[`CSPS_B_SIXTEEN]    = sixteen_bit_type_flag;
        state_word[`CSPS_B_POWERED]    = socket_powered_state;
        state_word[`CSPS_B_DETECT2]    = detect_two_level;
        state_word[`CSPS_B_DETECT1]    = detect_one_level;
        state_word[`CSPS_B_STATUS]     = pins.status_change;
        next_rd_valid = i_rd_en;
        next_rd_data  = 32'h0000_0000;
        if (i_rd_en && (i_rd_addr == `CSPS_OFS_STATE)) begin
            // Only the documented offset answers with the state.
            next_rd_data = state_word;
        end
    end

    // Register the read answer; writes to this offset have no effect.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rd_data  <= 32'h0000_0000;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_data  <= next_rd_data;
            o_rd_valid <= next_rd_valid;
        end
    end

endmodule : csps_state_reg

// ===== testbench/csps_state_reg_props.sv
// Concurrent checks on the ports of the socket present state register.
`timescale 1ns/10ps
module csps_state_reg_props (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    // Watched ports
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_rd_addr,
    input  wire logic        i_five_volt_disable,
    input  wire logic        i_interrog_busy,
    input  wire logic        i_socket_powered,
    input  wire logic        i_global_reset_pin,
    input  wire logic        i_pci_reset_pin,
    input  wire logic        i_ready_irq_pin,
    input  wire logic        i_detect_one_pin,
    input  wire logic        i_status_change_pin,
    input  wire logic [31:0] o_rd_data,
    input  wire logic        o_rd_valid,
    input  wire logic [3:0]  o_event_set
);
    // -----------------------------------------------------------------
    // Helper counter and defaults
    // -----------------------------------------------------------------
    logic [3:0] since_rst; // Cycles since reset, saturating, so pin paths have settled.
    logic       hit;       // A read of the state offset.

    // Counts up after reset and stops at its top.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            since_rst <= 4'h0;
        end else if (since_rst != 4'hF) begin
            since_rst <= since_rst + 4'h1;
        end
    end
    assign hit = i_rd_en && (i_rd_addr == 8'h08);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // Each read is answered exactly one cycle later.
    property p_valid; i_rd_en |=> o_rd_valid; endproperty
    a_valid: assert property (p_valid) else $error("read not answered");
    // An idle cycle or another offset returns zero.
    property p_other; !hit |=> o_rd_data == 32'h0000_0000; endproperty
    a_other: assert property (p_other) else $error("data not zero");
    // Reserved bits always read zero.
    property p_rsvd; o_rd_valid |-> o_rd_data[27:14] == 14'h0000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    // Bit 28 reads as the inverse of the five volt disable control.
    property p_five; hit ##1 $stable(i_five_volt_disable) |-> o_rd_data[28] == !i_five_volt_disable;
    endproperty
    a_five: assert property (p_five) else $error("bit 28 wrong");
    // Bit 3 shows the powered state.
    property p_power; hit && $stable(i_socket_powered) && since_rst > 4'h2
        |=> o_rd_data[3] == $past(i_socket_powered); endproperty
    a_power: assert property (p_power) else $error("bit 3 wrong");
    // A change of powered state raises its event two edges later.
    property p_event; $changed(i_socket_powered) && since_rst > 4'h6 && !$past(i_pci_reset_pin)
        && !$past(i_global_reset_pin) |-> ##2 o_event_set[3]; endproperty
    a_event: assert property (p_event) else $error("power event missing");
    // Bit 6 shows a settled ready pin level.
    property p_ready; ($stable(i_ready_irq_pin) && since_rst > 4'h6) [*5] ##0 hit
        |=> o_rd_data[6] == $past(i_ready_irq_pin); endproperty
    a_ready: assert property (p_ready) else $error("bit 6 wrong");
    // Bit 0 shows a settled status pin level.
    property p_status; ($stable(i_status_change_pin) && since_rst > 4'h6) [*5] ##0 hit
        |=> o_rd_data[0] == $past(i_status_change_pin); endproperty
    a_status: assert property (p_status) else $error("bit 0 wrong");
    // Bit 1 shows a settled detect level outside identification.
    property p_detect; ($stable(i_detect_one_pin) && !i_interrog_busy && since_rst > 4'h6) [*5]
        ##0 hit |=> o_rd_data[1] == $past(i_detect_one_pin); endproperty
    a_detect: assert property (p_detect) else $error("bit 1 wrong");
endmodule : csps_state_reg_props

bind csps_state_reg csps_state_reg_props i_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .i_five_volt_disable(i_five_volt_disable),
    .i_interrog_busy(i_interrog_busy), .i_socket_powered(i_socket_powered),
    .i_global_reset_pin(i_global_reset_pin), .i_pci_reset_pin(i_pci_reset_pin),
    .i_ready_irq_pin(i_ready_irq_pin), .i_detect_one_pin(i_detect_one_pin),
    .i_status_change_pin(i_status_change_pin), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_event_set(o_event_set));

// ===== testbench/csps_card_model.sv
// Behavioural card in the socket, driving the card-side pins.
`timescale 1ns/10ps
module csps_card_model (
    // Card controls from the bench
    input  wire logic i_inserted,
    input  wire logic i_ready,
    input  wire logic i_status,
    // Pins toward the socket
    output logic      o_detect_one,
    output logic      o_detect_two,
    output logic      o_ready,
    output logic      o_status
);
    // Detect pins are low while seated; the second contact lags to mimic skew.
    assign o_detect_one = !i_inserted;
    assign #3 o_detect_two = !i_inserted;
    // Ready and status levels come straight from the card.
    assign o_ready  = i_ready;
    assign o_status = i_status;
endmodule : csps_card_model

// ===== testbench/csps_state_reg_tb.sv
// Self-checking bench for the socket present state register.
`timescale 1ns/10ps
module csps_state_reg_tb;
    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic        i_clk_sys = 1'b0, i_sys_rst = 1'b1;   // Clock and reset.
    logic        rd_en = 1'b0, we = 1'b0, done = 1'b0;  // Strobes.
    logic [7:0]  rd_addr = 8'h00;                       // Read offset.
    logic [31:0] rd_data, force_data = 32'h0;           // Read and force words.
    logic        rd_valid, five_dis = 1'b0, pme = 1'b0; // Valid and controls.
    logic        busy = 1'b0, powered = 1'b0;           // Interrogation, power.
    logic        bad = 1'b0, loss = 1'b0;               // Power status pulses.
    logic        glob = 1'b0, pci = 1'b0;               // Reset pins.
    logic        card_in = 1'b0, card_rdy = 1'b0;       // Card model controls.
    logic        card_sts = 1'b0;                       // Card status level.
    logic        det1, det2, rdy, sts;                  // Card pins.
    logic [3:0]  ev, ev_seen = 4'h0;                    // Events and their history.
    csps_pkg::csps_interrog_t result = 7'h00;            // Interrogation result.
    int          bad_count = 0, tests_run = 0;          // Counters.

    // Clock of 8 ns period.
    always #4 i_clk_sys = !i_clk_sys;
    // Collects every event pulse.
    always @(posedge i_clk_sys) ev_seen <= ev_seen | ev;

    csps_card_model i_card (.i_inserted(card_in), .i_ready(card_rdy), .i_status(card_sts),
        .o_detect_one(det1), .o_detect_two(det2), .o_ready(rdy), .o_status(sts));
    csps_state_reg i_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_rd_en(rd_en),
        .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_force_we(we),
        .i_force_data(force_data), .i_five_volt_disable(five_dis), .i_pme_enable(pme),
        .i_interrog_busy(busy), .i_interrog_done(done), .i_interrog_result(result),
        .i_socket_powered(powered), .i_bad_supply_req(bad), .i_removal_loss(loss),
        .i_global_reset_pin(glob), .i_pci_reset_pin(pci), .i_ready_irq_pin(rdy),
        .i_detect_two_pin(det2), .i_detect_one_pin(det1), .i_status_change_pin(sts),
        .o_event_set(ev));

    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    // Compares a seen value with the expected one.
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Waits a number of cycles.
    task idle(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : idle
    // One read from a rising edge: taken at the next edge, answer checked while it stands.
    task rd(input logic [7:0] a, input logic [31:0] exp);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge i_clk_sys);
        rd_en <= 1'b0;
        @(negedge i_clk_sys);
        chk("valid", {31'h0, rd_valid}, 32'h1);
        chk("state", rd_data, exp);
        @(posedge i_clk_sys);
    endtask : rd
    // One force register write.
    task wr(input logic [31:0] d);
        @(posedge i_clk_sys);
        we         <= 1'b1;
        force_data <= d;
        @(posedge i_clk_sys);
        we <= 1'b0;
    endtask : wr
    // Interrogation done pulse with a given result.
    task interrog(input logic [6:0] r);
        @(posedge i_clk_sys);
        done   <= 1'b1;
        busy   <= 1'b0;
        result <= r;
        @(posedge i_clk_sys);
        done <= 1'b0;
    endtask : interrog
    // Prints the counts and the verdict, then stops.
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Watchdog far beyond the some 130 cycles of the sequence.
    initial begin
        #40000;
        bad_count++;
        end_sim();
    end

    // -----------------------------------------------------------------
    // Sequence
    // -----------------------------------------------------------------
    initial begin
        idle(3);
        i_sys_rst <= 1'b0;
        idle(4);
        rd(8'h08, 32'h3000_0006);
        rd(8'h0C, 32'h0000_0000);
        five_dis <= 1'b1;
        rd(8'h08, 32'h2000_0006);
        five_dis <= 1'b0;
        wr(32'hE000_0000);
        rd(8'h08, 32'hD000_0006);
        wr(32'h0000_0000);
        rd(8'h08, 32'h3000_0006);
        // Insertion during identification must not show on the detect bits.
        busy    <= 1'b1;
        card_in <= 1'b1;
        idle(6);
        rd(8'h08, 32'h3000_0006);
        interrog(7'h1A);
        idle(6);
        rd(8'h08, 32'h3000_0C20);
        chk("detect events", {30'h0, ev_seen[2:1]}, 32'h3);
        result <= 7'h7D;
        idle(2);
        rd(8'h08, 32'h3000_0C20);
        wr(32'h0000_2010);
        rd(8'h08, 32'h3000_2C30);
        interrog(7'h05);
        rd(8'h08, 32'h3000_0090);
        interrog(7'h05);
        rd(8'h08, 32'h3000_0090);
        interrog(7'h12);
        rd(8'h08, 32'h3000_0820);
        // Fresh pin levels must not reach the register at once.
        card_rdy <= 1'b1;
        card_sts <= 1'b1;
        rd(8'h08, 32'h3000_0820);
        idle(4);
        rd(8'h08, 32'h3000_0861);
        chk("status event", {31'h0, ev_seen[0]}, 32'h1);
        powered <= 1'b1;
        idle(3);
        rd(8'h08, 32'h3000_0869);
        chk("power event", {31'h0, ev_seen[3]}, 32'h1);
        bad  <= 1'b1;
        loss <= 1'b1;
        idle(1);
        bad  <= 1'b0;
        loss <= 1'b0;
        idle(2);
        rd(8'h08, 32'h3000_0B69);
        // PCI reset is ignored while power management is enabled.
        pme <= 1'b1;
        pci <= 1'b1;
        idle(6);
        rd(8'h08, 32'h3000_0B69);
        pci <= 1'b0;
        idle(6);
        rd(8'h08, 32'h3000_0B69);
        pme <= 1'b0;
        pci <= 1'b1;
        idle(6);
        rd(8'h08, 32'h3000_0049);
        pci <= 1'b0;
        pme <= 1'b1;
        idle(6);
        bad <= 1'b1;
        idle(1);
        bad <= 1'b0;
        idle(2);
        rd(8'h08, 32'h3000_0249);
        glob <= 1'b1;
        idle(6);
        rd(8'h08, 32'h3000_0049);
        glob <= 1'b0;
        idle(4);
        end_sim();
    end
endmodule : csps_state_reg_tb
